// >>> verilog/core_exec.sv
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module core_exec (
    input  wire logic                  clk,      // 20 MHz core clock
    input  wire logic                  arst_n,   // async reset, low
    input  wire core_exec_pkg::apb_req_t apb_req, // apb request
    output var  core_exec_pkg::apb_rsp_t apb_rsp, // apb answer
    output logic                       ret_req   // return pulse
);

    ////////////////////////////////////////////////////////////////////
    // architectural state

    logic        ext_en;
    logic [17:0] ir;
    logic [7:0]  wreg;
    logic [3:0]  bank_select_reg;
    logic [20:0] table_pointer;
    logic [7:0]  table_latch;
    logic        flag_n;
    logic        flag_z;
    logic        skipped;
    logic [11:0] fsr [3];
    logic [7:0]  hold [core_exec_pkg::HOLD_COUNT];
    logic [7:0]  ram [core_exec_pkg::RAM_WORDS];

    core_exec_pkg::qstate_t qst;
    core_exec_pkg::qstate_t next_qst;
    logic [1:0]  cyc;
    logic [1:0]  cyc_last;

    ////////////////////////////////////////////////////////////////////
    // apb decode

    logic [14:0] pa;
    logic        acc;
    logic        wr_fire;
    logic        busy;
    logic        is_ctrl;
    logic        is_instr;
    logic        is_wreg;
    logic        is_bank;
    logic        is_tptr;
    logic        is_tlat;
    logic        is_stat;
    logic        is_fsr;
    logic        is_hold;
    logic        is_ram;
    logic        mapped;
    logic [1:0]  fsr_sel;
    logic [31:0] rdata;

    assign pa       = apb_req.paddr;
    assign acc      = apb_req.psel && apb_req.penable;
    assign wr_fire  = acc && apb_rsp.pready && apb_req.pwrite;
    assign busy     = (qst != core_exec_pkg::ST_IDLE);
    assign is_ctrl  = (pa == core_exec_pkg::OFF_CTRL);
    assign is_instr = (pa == core_exec_pkg::OFF_INSTR);
    assign is_wreg  = (pa == core_exec_pkg::OFF_WREG);
    assign is_bank  = (pa == core_exec_pkg::OFF_BANK);
    assign is_tptr  = (pa == core_exec_pkg::OFF_TPTR);
    assign is_tlat  = (pa == core_exec_pkg::OFF_TLAT);
    assign is_stat  = (pa == core_exec_pkg::OFF_STATUS);
    assign is_fsr   = (pa == core_exec_pkg::OFF_FSR0)
                   || (pa == core_exec_pkg::OFF_FSR1)
                   || (pa == core_exec_pkg::OFF_FSR_TWO);
    assign is_hold  = (pa[14:5] == core_exec_pkg::OFF_HOLD[14:5])
                   && (pa[1:0] == 2'b00);
    assign is_ram   = pa[14] && (pa[1:0] == 2'b00);
    assign mapped   = is_ctrl || is_instr || is_wreg || is_bank
                   || is_tptr || is_tlat || is_stat || is_fsr
                   || is_hold || is_ram;
    assign fsr_sel  = 2'(({27'h0, pa[6:2]} - 32'd7));

    always_comb begin
        rdata = 32'h0000_0000;
        if (is_ctrl) begin
            rdata[core_exec_pkg::CTRL_EXT_BIT] = ext_en;
        end else if (is_instr) begin
            rdata[17:0] = ir;
        end else if (is_wreg) begin
            rdata[7:0] = wreg;
        end else if (is_bank) begin
            rdata[3:0] = bank_select_reg;
        end else if (is_tptr) begin
            rdata[20:0] = table_pointer;
        end else if (is_tlat) begin
            rdata[7:0] = table_latch;
        end else if (is_stat) begin
            rdata[core_exec_pkg::ST_N_BIT]    = flag_n;
            rdata[core_exec_pkg::ST_Z_BIT]    = flag_z;
            rdata[core_exec_pkg::ST_BUSY_BIT] = busy;
            rdata[core_exec_pkg::ST_SKIP_BIT] = skipped;
            rdata[core_exec_pkg::ST_RET_BIT]  = ret_req;
        end else if (is_fsr) begin
            rdata[11:0] = fsr[fsr_sel];
        end else if (is_hold) begin
            rdata[7:0] = hold[pa[4:2]];
        end else if (is_ram) begin
            rdata[7:0] = ram[pa[13:2]];
        end
    end

    // answer one cycle into the access phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready  <= acc && !apb_rsp.pready;
            apb_rsp.prdata  <= rdata;
            apb_rsp.pslverr <= acc && !apb_rsp.pready && !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // instruction decode

    logic       issue;
    logic       is_tab_write;
    logic       is_xor_lit;
    logic       is_xor_file;
    logic       is_test_skip;
    logic       is_ptr_add;
    logic       is_ptr_sub;
    logic       is_ulnk;
    logic       next_two;
    logic       dest_file;
    logic       acc_bit;
    logic [7:0] fa;
    logic [7:0] lit;
    logic [5:0] k6;
    logic [1:0] fsr_op;
    core_exec_pkg::tptr_mode_t tmode;

    assign issue     = wr_fire && is_instr && !busy;
    assign lit       = ir[7:0];
    assign fa        = ir[7:0];
    assign dest_file = ir[9];
    assign acc_bit   = ir[8];
    assign k6        = ir[5:0];
    assign fsr_op    = ir[7:6];
    assign next_two  = ir[core_exec_pkg::INSTR_TWO_BIT];
    assign tmode     = core_exec_pkg::tptr_mode_t'(ir[1:0]);
    assign is_tab_write = (ir[15:2] == core_exec_pkg::OP_TAB_WRITE);
    assign is_xor_lit   = (ir[15:8] == core_exec_pkg::OP_XOR_LIT);
    assign is_xor_file  = (ir[15:10] == core_exec_pkg::OP_XOR_FILE);
    assign is_test_skip = (ir[15:9] == core_exec_pkg::OP_TEST_SKIP);
    // pointer literal ops exist only with the extended set on
    assign is_ptr_add = ext_en
                     && (ir[15:8] == core_exec_pkg::OP_PTR_ADD);
    assign is_ptr_sub = ext_en
                     && (ir[15:8] == core_exec_pkg::OP_PTR_SUB);
    assign is_ulnk   = (is_ptr_add || is_ptr_sub)
                    && (fsr_op == core_exec_pkg::FSR_TWO_RET);

    ////////////////////////////////////////////////////////////////////
    // file address and data path

    logic        indexed;
    logic [11:0] faddr;
    logic [7:0]  fval;
    logic [7:0]  xres;
    logic [7:0]  xin;
    logic [1:0]  fsr_idx;
    logic [11:0] fsr_adj;

    assign indexed = !acc_bit && ext_en
                  && (fa <= core_exec_pkg::INDEX_LIMIT);
    assign faddr   = acc_bit ? {bank_select_reg, fa}
                   : indexed ? fsr[2] + {4'h0, fa}
                   : (fa < core_exec_pkg::ACCESS_SPLIT) ? {4'h0, fa}
                   : {core_exec_pkg::ACCESS_HIGH, fa};
    assign fval    = ram[faddr];
    assign xin     = is_xor_lit ? lit : fval;
    assign xres    = wreg ^ xin;
    assign fsr_idx = is_ulnk ? 2'd2 : fsr_op;
    assign fsr_adj = is_ptr_add ? fsr[fsr_idx] + {6'h00, k6}
                   : fsr[fsr_idx] - {6'h00, k6};

    ////////////////////////////////////////////////////////////////////
    // quadrature sequencer: four clocks per instruction cycle

    logic q4;
    logic first;
    logic done;

    assign q4    = (qst == core_exec_pkg::ST_Q4);
    assign first = q4 && (cyc == 2'd0);
    assign done  = q4 && (cyc == cyc_last);

    always_comb begin
        next_qst = qst;
        case (qst)
            core_exec_pkg::ST_IDLE: begin
                if (issue) begin
                    next_qst = core_exec_pkg::ST_Q1;
                end
            end
            core_exec_pkg::ST_Q1: next_qst = core_exec_pkg::ST_Q2;
            core_exec_pkg::ST_Q2: next_qst = core_exec_pkg::ST_Q3;
            core_exec_pkg::ST_Q3: next_qst = core_exec_pkg::ST_Q4;
            core_exec_pkg::ST_Q4: begin
                next_qst = done ? core_exec_pkg::ST_IDLE
                                : core_exec_pkg::ST_Q1;
            end
            default: next_qst = core_exec_pkg::ST_IDLE;
        endcase
    end

    logic [1:0] skip_last;
    logic [1:0] base_last;

    // a zero test throws away the fetched word(s) as no-op cycles
    assign skip_last = !(is_test_skip && fval == 8'h00) ? base_last
                     : next_two ? 2'd2 : 2'd1;
    assign base_last = (is_tab_write || is_ulnk) ? 2'd1 : 2'd0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            qst      <= core_exec_pkg::ST_IDLE;
            cyc      <= 2'd0;
            cyc_last <= 2'd0;
        end else begin
            qst <= next_qst;
            if (qst == core_exec_pkg::ST_IDLE) begin
                cyc <= 2'd0;
            end else if (q4) begin
                cyc <= cyc + 2'd1;
            end
            if (qst == core_exec_pkg::ST_Q1 && cyc == 2'd0) begin
                cyc_last <= skip_last;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            skipped <= 1'b0;
            ret_req <= 1'b0;
        end else begin
            ret_req <= done && is_ulnk;
            if (first && is_test_skip) begin
                skipped <= (fval == 8'h00);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // table pointer and holding registers

    logic [20:0] tptr_inc;
    logic [20:0] tptr_dec;
    logic        tw_pre;
    logic        tw_last;

    assign tptr_inc = table_pointer + 21'h00_0001;
    assign tptr_dec = table_pointer - 21'h00_0001;
    assign tw_pre   = first && is_tab_write
                   && (tmode == core_exec_pkg::TP_PRE_INC);
    assign tw_last  = q4 && (cyc == 2'd1) && is_tab_write;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            table_pointer <= 21'h00_0000;
        end else if (tw_pre) begin
            table_pointer <= tptr_inc;
        end else if (tw_last && tmode == core_exec_pkg::TP_POST_INC) begin
            table_pointer <= tptr_inc;
        end else if (tw_last && tmode == core_exec_pkg::TP_POST_DEC) begin
            table_pointer <= tptr_dec;
        end else if (wr_fire && is_tptr && !busy) begin
            table_pointer <= apb_req.pwdata[20:0];
        end
    end

    // bit 0 of the index is the low/high byte of a program word;
    // nothing here ever reaches program memory itself
    genvar h;
    generate
        for (h = 0; h < 8; h++) begin : g_hold
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    hold[h] <= 8'hFF;
                end else if (tw_last && table_pointer[2:0] == 3'(h)) begin
                    hold[h] <= table_latch;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // working register, flags, configuration

    logic wr_w;

    assign wr_w = first && (is_xor_lit || (is_xor_file && !dest_file));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wreg <= 8'h00;
        end else if (wr_w) begin
            wreg <= xres;
        end else if (wr_fire && is_wreg && !busy) begin
            wreg <= apb_req.pwdata[7:0];
        end
    end

    // only the xor ops touch the flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_n <= 1'b0;
            flag_z <= 1'b0;
        end else if (first && (is_xor_lit || is_xor_file)) begin
            flag_n <= xres[7];
            flag_z <= (xres == 8'h00);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_en          <= core_exec_pkg::RST_EXT;
            bank_select_reg <= 4'h0;
            table_latch     <= 8'h00;
            ir              <= 18'h0_0000;
        end else if (wr_fire && !busy) begin
            if (is_ctrl) begin
                ext_en <= apb_req.pwdata[core_exec_pkg::CTRL_EXT_BIT];
            end
            if (is_bank) begin
                bank_select_reg <= apb_req.pwdata[3:0];
            end
            if (is_tlat) begin
                table_latch <= apb_req.pwdata[7:0];
            end
            if (is_instr) begin
                ir <= apb_req.pwdata[17:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // file select pointers and data memory

    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_fsr
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    fsr[p] <= 12'h000;
                end else if (first && (is_ptr_add || is_ptr_sub)
                             && fsr_idx == 2'(p)) begin
                    fsr[p] <= fsr_adj;
                end else if (wr_fire && !busy && is_fsr
                             && fsr_sel == 2'(p)) begin
                    fsr[p] <= apb_req.pwdata[11:0];
                end
            end
        end
    endgenerate

    // memory has no reset; software loads it
    always_ff @(posedge clk) begin
        if (first && is_xor_file && dest_file) begin
            ram[faddr] <= xres;
        end else if (wr_fire && !busy && is_ram) begin
            ram[pa[13:2]] <= apb_req.pwdata[7:0];
        end
    end

endmodule
`default_nettype wire

// >>> verilog/core_exec_pkg.sv
// What this block does
// - low opcode bits pick table pointer mode
// - pointer low three bits pick holding register
// - table pointer is 21 bits, wraps
// - pointer bit 0 picks low/high byte
// - table write only stages holding data
// - zero file register skips, two cycles
// - skipped two-word instruction costs three cycles
// - access bit picks access bank or bank
// - extended, access bank, f<=5Fh is indexed
// - literal xor into working reg, N Z
// - literal xor upper byte 0000 1010
// - file xor, destination bit picks target
// - file xor decoded from 0001 10da
// - extended set off after reset
// - extended set adds pointer literal ops
// - pointer-two variants also return
`default_nettype none
package core_exec_pkg;
    localparam int unsigned ADDR_W       = 15;
    localparam int unsigned TPTR_W       = 21;
    localparam int unsigned DADDR_W      = 12;
    localparam int unsigned Q_PER_CYCLE  = 4;
    localparam int unsigned HOLD_COUNT   = 8;
    localparam int unsigned RAM_WORDS    = 4096;

    localparam logic [14:0] OFF_CTRL     = 15'h0000;
    localparam logic [14:0] OFF_INSTR    = 15'h0004;
    localparam logic [14:0] OFF_WREG     = 15'h0008;
    localparam logic [14:0] OFF_BANK     = 15'h000C;
    localparam logic [14:0] OFF_TPTR     = 15'h0010;
    localparam logic [14:0] OFF_TLAT     = 15'h0014;
    localparam logic [14:0] OFF_STATUS   = 15'h0018;
    localparam logic [14:0] OFF_FSR0     = 15'h001C;
    localparam logic [14:0] OFF_FSR1     = 15'h0020;
    localparam logic [14:0] OFF_FSR_TWO  = 15'h0024;
    localparam logic [14:0] OFF_HOLD     = 15'h0040;
    localparam logic [14:0] OFF_RAM      = 15'h4000;

    localparam int unsigned CTRL_EXT_BIT = 0;
    localparam int unsigned INSTR_TWO_BIT = 16;
    localparam int unsigned ST_N_BIT     = 0;
    localparam int unsigned ST_Z_BIT     = 1;
    localparam int unsigned ST_BUSY_BIT  = 2;
    localparam int unsigned ST_SKIP_BIT  = 3;
    localparam int unsigned ST_RET_BIT   = 4;

    localparam logic        RST_EXT      = 1'b0;
    localparam logic [7:0]  INDEX_LIMIT  = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  ACCESS_HIGH  = 4'hF;

    localparam logic [13:0] OP_TAB_WRITE = 14'h0003;
    localparam logic [7:0]  OP_XOR_LIT   = 8'h0A;
    localparam logic [5:0]  OP_XOR_FILE  = 6'h06;
    localparam logic [6:0]  OP_TEST_SKIP = 7'h33;
    localparam logic [7:0]  OP_PTR_ADD   = 8'hE8;
    localparam logic [7:0]  OP_PTR_SUB   = 8'hE9;
    localparam logic [1:0]  FSR_TWO_RET  = 2'b11;

    typedef enum logic [1:0] {
        TP_KEEP = 2'd0,
        TP_POST_INC = 2'd1,
        TP_POST_DEC = 2'd2,
        TP_PRE_INC = 2'd3
    } tptr_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_Q1   = 3'b001,
        ST_Q2   = 3'b011,
        ST_Q3   = 3'b010,
        ST_Q4   = 3'b110
    } qstate_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;
endpackage
`default_nettype wire

// >>> tb/core_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
module core_exec_properties (
    input wire logic                    clk,     // core clock
    input wire logic                    arst_n,  // async reset, low
    input wire core_exec_pkg::apb_req_t apb_req, // bus request
    input wire core_exec_pkg::apb_rsp_t apb_rsp, // bus answer
    input wire logic                    ret_req  // return pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    wire       acc  = apb_req.psel && apb_req.penable;
    wire       rdy  = apb_rsp.pready;
    wire [14:0] pa  = apb_req.paddr;
    wire       hole = !((pa[1:0] == 2'b00)
                   && (pa < 15'h0028 || pa[14]
                       || (pa >= 15'h0040 && pa < 15'h0060)));

    ////////////////////////////////////////////////////////////////////
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_wait;
        acc && !rdy;
    endsequence

    a_ready_after_wait: assert property (s_setup ##1 s_wait |=> rdy)
        else $error("pready missing after one access cycle");
    a_no_early_ready: assert property (s_setup |-> !rdy)
        else $error("pready during setup");
    a_ready_one_cycle: assert property (rdy |=> !rdy)
        else $error("pready held two cycles");
    a_ready_in_access: assert property (rdy |-> acc)
        else $error("pready outside access");
    a_err_unmapped: assert property (rdy && hole |-> apb_rsp.pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (rdy && !hole |-> !apb_rsp.pslverr)
        else $error("error on mapped address");
    a_ret_one_pulse: assert property (ret_req |=> !ret_req)
        else $error("return request held two cycles");
    a_reset_quiet: assert property (disable iff (1'b0)
        !arst_n |-> !rdy && !ret_req && !apb_rsp.pslverr)
        else $error("outputs active in reset");
endmodule
`default_nettype wire

// >>> tb/table_write_xor_skip_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module table_write_xor_skip_exec_bench;
    logic                    clk    = 1'b0;
    logic                    arst_n;
    core_exec_pkg::apb_req_t req    = '0;
    core_exec_pkg::apb_rsp_t rsp;
    logic                    ret_req;
    int                      num_errors  = 0;
    int                      checks_done = 0;
    int                      rets = 0;
    int                      seed = 17530;
    logic [31:0]             rd, w, v, e;
    logic [20:0]             p, q;
    logic [1:0]              m;
    logic                    er, d;
    logic [11:0] xi [5] = '{12'h2AB, 12'hF85, 12'h010, 12'h35F, 12'h060};

    always #25 clk = ~clk;
    always @(posedge clk) if (ret_req === 1'b1) rets <= rets + 1;

    core_exec dut_u (
        .clk     (clk),
        .arst_n  (arst_n),
        .apb_req (req),
        .apb_rsp (rsp),
        .ret_req (ret_req)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] flags(input logic [7:0] x);
        return {30'h0, x == 8'h00, x[7]};
    endfunction
    function automatic logic [31:0] tp_next(input logic [20:0] x,
                                            input logic [1:0] md);
        logic [20:0] y;
        y = (md == 2'd2) ? x - 21'd1 : (md == 2'd0) ? x : x + 21'd1;
        return {11'h0, y};
    endfunction
    function automatic logic [14:0] ra(input logic [11:0] i);
        return {1'b1, i, 2'b00};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [14:0] a,
                       input logic [31:0] dat);
        req.psel   <= 1'b1;
        req.pwrite <= wr;
        req.paddr  <= a;
        req.pwdata <= dat;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [14:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask
    task automatic exec(input logic [16:0] op, input int n);
        logic [31:0] bz;
        apb(1'b1, core_exec_pkg::OFF_INSTR, {15'h0, op});
        repeat (4 * n - 4) @(posedge clk);
        apb(1'b0, core_exec_pkg::OFF_STATUS, 32'h0000_0000);
        bz = {31'h0, rd[core_exec_pkg::ST_BUSY_BIT]};
        chk("busy", bz, 32'h0000_0001);
        apb(1'b0, core_exec_pkg::OFF_STATUS, 32'h0000_0000);
        bz = {31'h0, rd[core_exec_pkg::ST_BUSY_BIT]};
        chk("idle", bz, 32'h0000_0000);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end

    initial begin
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rchk("ctrl", core_exec_pkg::OFF_CTRL, 32'h0000_0000);
        rchk("hold", core_exec_pkg::OFF_HOLD, 32'h0000_00FF);
        apb(1'b1, 15'h0028, 32'h0000_0001);
        chk("err", {31'h0, er}, 32'h0000_0001);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            w = $random(seed) & 32'h0000_00FF;
            v = (i == 0) ? w : $random(seed) & 32'h0000_00FF;
            e = w ^ v;
            apb(1'b1, core_exec_pkg::OFF_WREG, w);
            exec({1'b0, core_exec_pkg::OP_XOR_LIT, v[7:0]}, 1);
            rchk("w", core_exec_pkg::OFF_WREG, e);
            apb(1'b0, core_exec_pkg::OFF_STATUS, 32'h0000_0000);
            chk("nz", rd & 32'h0000_0003, flags(e[7:0]));
        end
        $display("test xor literal done");
        apb(1'b1, core_exec_pkg::OFF_BANK, 32'h0000_0002);
        apb(1'b1, core_exec_pkg::OFF_FSR_TWO, 32'h0000_0300);
        for (int i = 0; i < 5; i++) begin
            w = $random(seed) & 32'h0000_00FF;
            v = $random(seed) & 32'h0000_00FF;
            d = $random(seed);
            e = w ^ v;
            apb(1'b1, core_exec_pkg::OFF_CTRL, {31'h0, i > 2});
            apb(1'b1, ra(xi[i]), v);
            apb(1'b1, core_exec_pkg::OFF_WREG, w);
            exec({1'b0, core_exec_pkg::OP_XOR_FILE, d, i == 0, xi[i][7:0]},
                 1);
            rchk("wf_w", core_exec_pkg::OFF_WREG, d ? w : w ^ v);
            rchk("wf_f", ra(xi[i]), d ? w ^ v : v);
            apb(1'b0, core_exec_pkg::OFF_STATUS, 32'h0000_0000);
            chk("wf_nz", rd & 32'h0000_0003, flags(e[7:0]));
        end
        $display("test xor file done");
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? (($random(seed) | 1) & 32'h0000_00FF) : 0;
            apb(1'b1, ra(12'h240), v);
            exec({i == 2, core_exec_pkg::OP_TEST_SKIP, 1'b1, 8'h40},
                 i + 1);
            apb(1'b0, core_exec_pkg::OFF_STATUS, 32'h0000_0000);
            chk("skip", {31'h0, rd[3]}, {31'h0, i != 0});
        end
        $display("test skip done");
        apb(1'b1, core_exec_pkg::OFF_WREG, 32'h0000_0000);
        exec({1'b0, core_exec_pkg::OP_XOR_LIT, 8'h80}, 1);
        for (int i = 0; i < 6; i++) begin
            p = (i == 4) ? 21'h1F_FFFF : (i == 5) ? 21'h0 : $random(seed);
            m = (i == 4) ? 2'd1 : (i == 5) ? 2'd2 : i[1:0];
            v = $random(seed) & 32'h0000_00FF;
            q = (m == 2'd3) ? p + 21'd1 : p;
            apb(1'b1, core_exec_pkg::OFF_TPTR, {11'h0, p});
            apb(1'b1, core_exec_pkg::OFF_TLAT, v);
            exec({1'b0, core_exec_pkg::OP_TAB_WRITE, m}, 2);
            rchk("tptr", core_exec_pkg::OFF_TPTR,
                 tp_next(p, m));
            rchk("hreg", core_exec_pkg::OFF_HOLD + {q[2:0], 2'b00},
                 v);
            apb(1'b0, core_exec_pkg::OFF_STATUS, 32'h0000_0000);
            chk("tw_nz", rd & 32'h0000_0003, 32'h0000_0001);
        end
        $display("test table write done");
        apb(1'b1, core_exec_pkg::OFF_CTRL, 32'h0000_0000);
        apb(1'b1, core_exec_pkg::OFF_FSR1, 32'h0000_03FF);
        exec({1'b0, core_exec_pkg::OP_PTR_ADD, 2'd1, 6'h23}, 1);
        rchk("fsr_off", core_exec_pkg::OFF_FSR1, 32'h0000_03FF);
        apb(1'b1, core_exec_pkg::OFF_CTRL, 32'h0000_0001);
        exec({1'b0, core_exec_pkg::OP_PTR_ADD, 2'd1, 6'h23}, 1);
        rchk("fsr_add", core_exec_pkg::OFF_FSR1, 32'h0000_0422);
        exec({1'b0, core_exec_pkg::OP_PTR_SUB, 2'd1, 6'h22}, 1);
        rchk("fsr_sub", core_exec_pkg::OFF_FSR1, 32'h0000_0400);
        apb(1'b1, core_exec_pkg::OFF_FSR_TWO, 32'h0000_03FF);
        e = rets;
        exec({1'b0, core_exec_pkg::OP_PTR_ADD,
              core_exec_pkg::FSR_TWO_RET, 6'h23}, 2);
        exec({1'b0, core_exec_pkg::OP_PTR_SUB,
              core_exec_pkg::FSR_TWO_RET, 6'h22}, 2);
        rchk("indirect_pointer_two", core_exec_pkg::OFF_FSR_TWO, 32'h0000_0400);
        chk("rets", rets, e + 2);
        $display("test extended done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rchk("ctrl_rst", core_exec_pkg::OFF_CTRL, 32'h0000_0000);
        rchk("st_rst", core_exec_pkg::OFF_STATUS, 32'h0000_0000);
        $display("test second reset done");
        test_done();
    end
endmodule

bind core_exec core_exec_properties chk_u (
    .clk     (clk),
    .arst_n  (arst_n),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp),
    .ret_req (ret_req)
);
`default_nettype wire
